//--- drive_safety_pkg.sv
// constants, types and register map of the drive speed safety monitor
package drive_safety_pkg;
  // timing: delays are programmed in milliseconds
  localparam int CLK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_STANDSTILL = 8'h08;
  localparam logic [7:0] OFS_LOWER_CAP = 8'h0c;
  localparam logic [7:0] OFS_UPPER_CAP = 8'h10;
  localparam logic [7:0] OFS_SHORT_DLY = 8'h14;
  localparam logic [7:0] OFS_LONG_DLY = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_COMMAND = 8'h28;
  // control register fields
  localparam int CTRL_LSG_EN = 0;
  localparam int CTRL_TYPE_LO = 1;
  localparam int CTRL_MAX_EN = 4;
  localparam int CTRL_SEL_LO = 5;
  localparam int CTRL_DOOR_EN = 7;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h02;
  // cap selector codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_PAIR_A = 2'h1;
  localparam logic [1:0] SEL_PAIR_B = 2'h2;
  // frequency and delay reset values
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [15:0] STANDSTILL_RST = 16'h0000;
  localparam logic [15:0] LOWER_CAP_RST = 16'hffff;
  localparam logic [15:0] UPPER_CAP_RST = 16'hffff;
  localparam logic [15:0] SHORT_DLY_RST = 16'h0000;
  localparam logic [15:0] LONG_DLY_RST = 16'h0000;
  // interrupt status bits
  localparam int IRQ_TOFF = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_DOOR = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // command register bit
  localparam int CMD_FAULT_RST = 0;

  typedef enum logic [2:0] {
    G_OFF, G_LIMIT, G_RAMP, G_STOP
  } guard_state_type;

  typedef struct packed {
    logic run;
    logic ramp_stop;
    logic freewheel;
    logic ctrl_stop;
    logic error;
    logic [1:0] pair_a;
    logic [1:0] pair_b;
  } pins_type;
endpackage : drive_safety_pkg

//--- drive_speed_safety_monitor.sv
// speed guards, torque-off latch and door release timer with apb registers
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module drive_speed_safety_monitor #(
  parameter int MS_CYC = drive_safety_pkg::MS_CYCLES
) (
  input wire logic REF_CLK, // 125 mhz clock
  input wire logic SYS_RST, // sync reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped
  input wire logic [15:0] STATOR_FREQ, // stator frequency
  input wire logic RUN_CMD, // run command pin
  input wire logic RAMP_STOP, // ramp stop pin
  input wire logic FREEWHEEL_STOP, // freewheel stop pin
  input wire logic CTRL_STOP, // controlled stop ramp
  input wire logic ERROR_DET, // detected error pin
  input wire logic [1:0] INPUT_PAIR_A, // inputs 3/4
  input wire logic [1:0] INPUT_PAIR_B, // inputs 5/6
  output logic TORQUE_OFF, // torque removed
  output logic SAFETY_TRIP_FAULT, // safety fault
  output logic GUARD_REF_SEL, // 1: setpoint limits ref
  output logic [15:0] LIMIT_REF, // reference ceiling
  output logic FIRST_LOGIC_OUTPUT, // door lock release
  output logic IRQ // interrupt level
);
  drive_safety_pkg::pins_type s1_q, s2_q, s3_q;
  drive_safety_pkg::guard_state_type state_q, state_d;
  logic [7:0] ctrl_q;
  logic [15:0] sp_q, ssl_q, low_q, up_q, sdly_q, ldly_q;
  logic [2:0] stat_q, mask_q, ev;
  logic toff_q, fault_q, ref_q, door_q, arm_q, tick_q;
  logic [15:0] dcnt_q, cap;
  logic [31:0] tcnt_q;
  logic [31:0] rd;
  logic rd_err;
  logic wr, setup, req, stop_ev, at_ssl, trip, g_toff;
  logic run_rise, cstop_rise, long_ev, toff_rise, fault_rise;
  logic [2:0] gtype;
  logic [1:0] sel;

  function automatic logic [31:0] z16(input logic [15:0] v);
    z16 = {16'h0000, v};
  endfunction : z16

  // pins come from another domain: two flops before any use
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {RUN_CMD, RAMP_STOP, FREEWHEEL_STOP, CTRL_STOP, ERROR_DET,
        INPUT_PAIR_A, INPUT_PAIR_B};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign run_rise = s2_q.run & ~s3_q.run;
  assign cstop_rise = s2_q.ctrl_stop & ~s3_q.ctrl_stop;
  assign req = ctrl_q[drive_safety_pkg::CTRL_LSG_EN];
  assign gtype = ctrl_q[drive_safety_pkg::CTRL_TYPE_LO +: 3];
  assign sel = ctrl_q[drive_safety_pkg::CTRL_SEL_LO +: 2];
  assign stop_ev = s2_q.ramp_stop | s2_q.freewheel | s2_q.error;
  assign at_ssl = STATOR_FREQ <= ssl_q;

  // cap selection; a split pair counts as low, the safer cap
  always_comb begin
    unique case (sel)
      drive_safety_pkg::SEL_PAIR_A: cap = &s2_q.pair_a ? up_q : low_q;
      drive_safety_pkg::SEL_PAIR_B: cap = &s2_q.pair_b ? up_q : low_q;
      default: cap = low_q;
    endcase
  end

  // supervision only: the trip never touches the reference path
  assign trip = ctrl_q[drive_safety_pkg::CTRL_MAX_EN]
    & (STATOR_FREQ >= cap);

  // limited-speed guard sequencing on deactivation, stop and error
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      drive_safety_pkg::G_OFF:
        if (req) begin
          state_d = (gtype != 3'h1 && STATOR_FREQ > sp_q) ?
            drive_safety_pkg::G_RAMP : drive_safety_pkg::G_LIMIT;
        end
      drive_safety_pkg::G_LIMIT:
        if (stop_ev || (s2_q.ctrl_stop && gtype == 3'h3)) begin
          state_d = drive_safety_pkg::G_STOP;
        end else if (!req) begin
          state_d = drive_safety_pkg::G_OFF;
        end
      drive_safety_pkg::G_RAMP:
        if (stop_ev || (s2_q.ctrl_stop && gtype == 3'h3)) begin
          state_d = drive_safety_pkg::G_STOP;
        end else if (STATOR_FREQ <= sp_q) begin
          state_d = req ? drive_safety_pkg::G_LIMIT :
            drive_safety_pkg::G_OFF;
        end else if (!req && (gtype < 3'h2 || gtype > 3'h4)) begin
          state_d = drive_safety_pkg::G_OFF;
        end
      drive_safety_pkg::G_STOP:
        if (at_ssl) begin
          state_d = drive_safety_pkg::G_OFF;
        end
      default: state_d = drive_safety_pkg::G_OFF;
    endcase
  end

  assign g_toff = state_q == drive_safety_pkg::G_STOP && at_ssl
    && gtype >= 3'h1 && gtype <= 3'h3;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_q <= drive_safety_pkg::G_OFF;
      ref_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ref_q <= state_d != drive_safety_pkg::G_OFF;
    end
  end

  // torque-off: set wins over the run-command release
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      toff_q <= 1'b0;
    end else if (g_toff || trip) begin
      toff_q <= 1'b1;
    end else if (run_rise && !fault_q) begin
      toff_q <= 1'b0;
    end
  end

  // fault is held until software resets it after the cause is gone
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      fault_q <= 1'b0;
    end else if (trip) begin
      fault_q <= 1'b1;
    end else if (wr && PADDR == drive_safety_pkg::OFS_COMMAND
      && PWDATA[drive_safety_pkg::CMD_FAULT_RST] && !s2_q.error) begin
      fault_q <= 1'b0;
    end
  end

  // millisecond enable pulse for the door timer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tcnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tcnt_q == 32'(MS_CYC - 1);
      tcnt_q <= (tcnt_q == 32'(MS_CYC - 1)) ? 32'h0 : tcnt_q + 32'h1;
    end
  end

  assign toff_rise = (g_toff || trip) && !toff_q;
  assign long_ev = (s2_q.ramp_stop & ~s3_q.ramp_stop)
    | (s2_q.freewheel & ~s3_q.freewheel) | toff_rise;

  // door release timer; a long event outranks a short one
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      dcnt_q <= 16'h0;
      arm_q <= 1'b0;
      door_q <= 1'b0;
    end else if (!ctrl_q[drive_safety_pkg::CTRL_DOOR_EN]) begin
      arm_q <= 1'b0;
      door_q <= 1'b0;
    end else if (long_ev) begin
      dcnt_q <= ldly_q;
      arm_q <= 1'b1;
      door_q <= 1'b0;
    end else if (cstop_rise) begin
      dcnt_q <= sdly_q;
      arm_q <= 1'b1;
      door_q <= 1'b0;
    end else if (run_rise) begin
      arm_q <= 1'b0;
      door_q <= 1'b0;
    end else if (arm_q && tick_q) begin
      if (dcnt_q == 16'h0) begin
        arm_q <= 1'b0;
        door_q <= 1'b1;
      end else begin
        dcnt_q <= dcnt_q - 16'h1;
      end
    end
  end

  // apb slave: zero wait, read data captured in the setup cycle
  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & PWRITE;
  assign PREADY = 1'b1;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= drive_safety_pkg::CTRL_RST;
      sp_q <= drive_safety_pkg::SETPOINT_RST;
      ssl_q <= drive_safety_pkg::STANDSTILL_RST;
      low_q <= drive_safety_pkg::LOWER_CAP_RST;
      up_q <= drive_safety_pkg::UPPER_CAP_RST;
      sdly_q <= drive_safety_pkg::SHORT_DLY_RST;
      ldly_q <= drive_safety_pkg::LONG_DLY_RST;
      mask_q <= drive_safety_pkg::IRQ_MASK_RST;
    end else if (wr) begin
      unique case (PADDR)
        drive_safety_pkg::OFS_CTRL: ctrl_q <= PWDATA[7:0];
        drive_safety_pkg::OFS_SETPOINT: sp_q <= PWDATA[15:0];
        drive_safety_pkg::OFS_STANDSTILL: ssl_q <= PWDATA[15:0];
        drive_safety_pkg::OFS_LOWER_CAP: low_q <= PWDATA[15:0];
        drive_safety_pkg::OFS_UPPER_CAP: up_q <= PWDATA[15:0];
        drive_safety_pkg::OFS_SHORT_DLY: sdly_q <= PWDATA[15:0];
        drive_safety_pkg::OFS_LONG_DLY: ldly_q <= PWDATA[15:0];
        drive_safety_pkg::OFS_IRQ_MASK: mask_q <= PWDATA[2:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event in the clearing cycle survives
  assign fault_rise = trip && !fault_q;
  assign ev = {(arm_q && tick_q && dcnt_q == 16'h0
    && !long_ev && !cstop_rise && !run_rise), fault_rise, toff_rise};

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stat_q <= '0;
    end else if (wr && PADDR == drive_safety_pkg::OFS_IRQ_STAT) begin
      stat_q <= (stat_q & ~PWDATA[2:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_comb begin
    rd = 32'h0;
    rd_err = 1'b0;
    unique case (PADDR)
      drive_safety_pkg::OFS_CTRL: rd = {24'h0, ctrl_q};
      drive_safety_pkg::OFS_SETPOINT: rd = z16(sp_q);
      drive_safety_pkg::OFS_STANDSTILL: rd = z16(ssl_q);
      drive_safety_pkg::OFS_LOWER_CAP: rd = z16(low_q);
      drive_safety_pkg::OFS_UPPER_CAP: rd = z16(up_q);
      drive_safety_pkg::OFS_SHORT_DLY: rd = z16(sdly_q);
      drive_safety_pkg::OFS_LONG_DLY: rd = z16(ldly_q);
      drive_safety_pkg::OFS_STATUS:
        rd = {25'h0, 3'(state_q), door_q, ref_q, fault_q, toff_q};
      drive_safety_pkg::OFS_IRQ_STAT: rd = {29'h0, stat_q};
      drive_safety_pkg::OFS_IRQ_MASK: rd = {29'h0, mask_q};
      drive_safety_pkg::OFS_COMMAND: rd = 32'h0;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h0 : rd;
      PSLVERR <= rd_err;
    end
  end

  assign TORQUE_OFF = toff_q;
  assign SAFETY_TRIP_FAULT = fault_q;
  assign GUARD_REF_SEL = ref_q;
  assign LIMIT_REF = sp_q;
  assign FIRST_LOGIC_OUTPUT = door_q;
  assign IRQ = |(stat_q & mask_q);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  a_max_trip: assert property (trip |=> toff_q && fault_q)
    else $error("cap reached without torque-off and fault");
  a_cap_none: assert property (sel == drive_safety_pkg::SEL_NONE
    |-> cap == low_q)
    else $error("unassigned selector not on lower cap");
  a_cap_pair: assert property (sel == drive_safety_pkg::SEL_PAIR_A
    && s2_q.pair_a == 2'h3 |-> cap == up_q)
    else $error("high pair not on upper cap");
  a_toff_hold: assert property (toff_q && !run_rise |=> toff_q)
    else $error("torque-off released without run");
  a_ramp_keep: assert property (state_q == drive_safety_pkg::G_RAMP
    && !req && !stop_ev && !s2_q.ctrl_stop && gtype == 3'h2
    && STATOR_FREQ > sp_q |=> ref_q)
    else $error("guard dropped before setpoint");
  a_ref_resume: assert property (state_q == drive_safety_pkg::G_LIMIT
    && !req && !stop_ev && !s2_q.ctrl_stop |=> !ref_q)
    else $error("reference not returned to channel");
  a_stop_toff: assert property (state_q == drive_safety_pkg::G_STOP
    && at_ssl && gtype == 3'h1 |=> toff_q)
    else $error("no torque-off at standstill");
  a_door_long: assert property (ctrl_q[drive_safety_pkg::CTRL_DOOR_EN]
    && long_ev |=> !door_q ##0 arm_q && dcnt_q == $past(ldly_q))
    else $error("long delay not loaded");
  a_door_run: assert property (run_rise && !long_ev && !cstop_rise
    |=> !door_q[*2])
    else $error("door released while powered");

  c_trip: cover property (trip ##1 toff_q);
  c_door: cover property ($rose(door_q));
  c_ramp: cover property (state_q == drive_safety_pkg::G_RAMP && !req);
  c_cstop: cover property (cstop_rise ##[1:1000] door_q);
endmodule : drive_speed_safety_monitor

//--- machine_model.sv
// machine model: pin driver and stator frequency response
`timescale 1ns/1ps
module machine_model (
  input wire logic clk, // clock
  input wire logic rst, // reset, high
  input wire drive_safety_pkg::pins_type req, // commanded pins
  input wire logic [15:0] tgt, // active channel reference
  input wire logic toff, // torque removed
  input wire logic ref_sel, // guard limits the reference
  input wire logic [15:0] lim, // reference ceiling
  output drive_safety_pkg::pins_type pins, // pins to the drive
  output logic [15:0] freq = 16'h0000 // stator frequency
);
  logic [15:0] goal;
  assign pins = req;
  // any stop or torque removal pulls the motor down; nothing holds speed
  always_comb begin
    goal = (ref_sel && lim < tgt) ? lim : tgt;
    if (toff || req.ramp_stop || req.freewheel || req.ctrl_stop || req.error)
      goal = 16'h0000;
  end
  always @(posedge clk) begin
    if (rst) freq <= 16'h0000;
    else if (freq + 16'h0002 <= goal) freq <= freq + 16'h0002;
    else if (freq >= goal + 16'h0002) freq <= freq - 16'h0002;
    else freq <= goal;
  end
endmodule : machine_model

//--- tb_drive_speed_safety_monitor.sv
// self-checking bench for the drive speed safety monitor
`timescale 1ns/1ps
module tb_drive_speed_safety_monitor;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rv;
  logic prdy, perr, irq, lerr, toff, flt, rsel, door;
  logic [15:0] freq, lim;
  logic [15:0] tgt = 16'h0000;
  drive_safety_pkg::pins_type req = '0;
  drive_safety_pkg::pins_type pin;
  logic [31:0] cv [6] = '{32'h50, 32'h0a, 32'h64, 32'hc8, 32'h2, 32'h4};
  int n_fail = 0;
  int samples_checked = 0;
  wire [3:0] o = {door, rsel, flt, toff};

  // small ms tick keeps door delays to tens of cycles
  drive_speed_safety_monitor #(.MS_CYC(10)) dut (.REF_CLK(clk), .SYS_RST(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .STATOR_FREQ(freq),
    .RUN_CMD(pin.run), .RAMP_STOP(pin.ramp_stop),
    .FREEWHEEL_STOP(pin.freewheel), .CTRL_STOP(pin.ctrl_stop),
    .ERROR_DET(pin.error), .INPUT_PAIR_A(pin.pair_a),
    .INPUT_PAIR_B(pin.pair_b), .TORQUE_OFF(toff), .SAFETY_TRIP_FAULT(flt),
    .GUARD_REF_SEL(rsel), .LIMIT_REF(lim), .FIRST_LOGIC_OUTPUT(door),
    .IRQ(irq));
  machine_model plant (.clk(clk), .rst(rst), .req(req), .tgt(tgt),
    .toff(toff), .ref_sel(rsel), .lim(lim), .pins(pin), .freq(freq));

  initial begin
    forever #4 clk = ~clk;
  end

  task wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task b1(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask : b1

  task cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy

  // one extra edge after release so a following setup never collides
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rv = prd;
    lerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rd

  task waitv(input int k, input logic v, input int n);
    int i;
    for (i = 0; i < n && o[k] !== v; i++) @(posedge clk);
    b1(o[k], v);
  endtask : waitv

  task rst_dut();
    req <= '0;
    tgt <= 16'h0000;
    rst <= 1'b1;
    cy(3);
    rst <= 1'b0;
    @(posedge clk);
  endtask : rst_dut

  task setup(input logic [7:0] c);
    int i;
    for (i = 0; i < 6; i++)
      wr(drive_safety_pkg::OFS_SETPOINT + 8'(4 * i), cv[i]);
    wr(drive_safety_pkg::OFS_CTRL, {24'h0, c});
  endtask : setup

  task t_regs();
    rst_dut();
    rd(drive_safety_pkg::OFS_CTRL, 32'h02);
    rd(drive_safety_pkg::OFS_UPPER_CAP, 32'hffff);
    rd(8'h2c, 32'h0);
    b1(lerr, 1'b1);
    b1(prdy, 1'b1);
  endtask : t_regs

  task t_trip();
    rst_dut();
    setup(8'h10);
    req.pair_a <= 2'h3;
    tgt <= 16'h96;
    waitv(0, 1'b1, 200);
    b1(freq <= 16'h68, 1'b1);
    b1(flt, 1'b1);
    chk({16'h0, lim}, 32'h50);
    rd(drive_safety_pkg::OFS_IRQ_STAT, 32'h3);
    b1(irq, 1'b0);
    wr(drive_safety_pkg::OFS_IRQ_MASK, 32'h3);
    b1(irq, 1'b1);
    wr(drive_safety_pkg::OFS_IRQ_STAT, 32'h3);
    b1(irq, 1'b0);
    tgt <= 16'h0;
    cy(60);
    b1(flt, 1'b1);
    wr(drive_safety_pkg::OFS_COMMAND, 32'h1);
    b1(flt, 1'b0);
    b1(toff, 1'b1);
    req.run <= 1'b1;
    waitv(0, 1'b0, 10);
  endtask : t_trip

  task t_caps();
    rst_dut();
    setup(8'h30);
    req.pair_a <= 2'h3;
    tgt <= 16'h96;
    cy(120);
    b1(toff, 1'b0);
    tgt <= 16'hfa;
    waitv(0, 1'b1, 100);
    b1(freq <= 16'hcc, 1'b1);
    rst_dut();
    setup(8'h50);
    req.pair_a <= 2'h3;
    tgt <= 16'h96;
    waitv(0, 1'b1, 200);
    rst_dut();
    setup(8'h40);
    req.pair_b <= 2'h3;
    tgt <= 16'hfa;
    cy(200);
    b1(toff, 1'b0);
  endtask : t_caps

  task t_stop(input int k);
    rst_dut();
    setup(8'h83);
    tgt <= 16'h3c;
    cy(40);
    b1(door, 1'b0);
    if (k == 0) req.ramp_stop <= 1'b1;
    else req.error <= 1'b1;
    cy(10);
    b1(rsel, 1'b1);
    waitv(0, 1'b1, 100);
    b1(freq <= 16'h0a, 1'b1);
    cy(36);
    b1(door, 1'b0);
    waitv(3, 1'b1, 40);
  endtask : t_stop

  task t_ctrl();
    rst_dut();
    setup(8'h87);
    tgt <= 16'h3c;
    cy(40);
    req.ctrl_stop <= 1'b1;
    cy(4);
    wr(drive_safety_pkg::OFS_CTRL, 32'h86);
    waitv(0, 1'b1, 100);
    b1(freq <= 16'h0a, 1'b1);
    req.ctrl_stop <= 1'b0;
    cy(20);
    b1(toff, 1'b1);
    req.run <= 1'b1;
    waitv(0, 1'b0, 10);
    rst_dut();
    setup(8'h80);
    tgt <= 16'h3c;
    cy(40);
    req.ctrl_stop <= 1'b1;
    cy(18);
    b1(door, 1'b0);
    waitv(3, 1'b1, 30);
  endtask : t_ctrl

  // second stop event mid-delay must push the release out again
  task t_free();
    rst_dut();
    setup(8'h80);
    tgt <= 16'h3c;
    cy(40);
    req.freewheel <= 1'b1;
    cy(30);
    req.ramp_stop <= 1'b1;
    cy(38);
    b1(door, 1'b0);
    waitv(3, 1'b1, 40);
    rd(drive_safety_pkg::OFS_IRQ_STAT, 32'h4);
    rst_dut();
    setup(8'h00);
    req.freewheel <= 1'b1;
    cy(80);
    b1(door, 1'b0);
  endtask : t_free

  task t_ramp();
    rst_dut();
    setup(8'h04);
    tgt <= 16'h96;
    cy(90);
    wr(drive_safety_pkg::OFS_CTRL, 32'h05);
    wr(drive_safety_pkg::OFS_CTRL, 32'h04);
    b1(rsel, 1'b1);
    waitv(2, 1'b0, 100);
    b1(freq <= 16'h50, 1'b1);
    cy(60);
    chk({16'h0, freq}, 32'h96);
  endtask : t_ramp

  initial begin
    t_regs();
    t_trip();
    t_caps();
    t_stop(0);
    t_stop(1);
    t_ctrl();
    t_free();
    t_ramp();
    wrap_up();
  end

  initial begin
    cy(20000);
    n_fail++;
    wrap_up();
  end
endmodule : tb_drive_speed_safety_monitor
